// ==== design/tlbm_pkg.sv ====
/*
 * Constants for the memory-mapped translation buffer window block:
 * window decode, entry geometry, field layouts and AHB-Lite register offsets.
 * Assumes a single 40 MHz clock and a synchronous active-high reset.
 */
// Operation
// R1: decode F3000000..F3FFFFFF as direct data array access.
// R2: data array access when address bits 31..24 equal F3.
// R3: address bits 16..12 pick index, bits 9..8 pick way.
// R4: with hash select set, index is bits 16..12 xor address space id 4..0.
// R5: data longword stored and returned in page entry low layout.
// R6: read and write act on the one longword at index and way.
// R7: 32-bit address for any access, 32-bit write data replaces longword.
// R8: writing valid bit zero invalidates the entry so it never hits.
// R9: replace way field may go wrong with duplicate page numbers and exceptions.
// R10: virtual page numbers are not cleared by reset.
// R11: software sets upper four page number bits to ones before enabling translation.
// R12: software invalidating an entry also sets upper four page number bits.
// R13: software runs privilege-changing code with translation off or fixed regions.
// R14: arrays reachable only in privileged mode.
// R15: only longword accesses on both array windows.
// R16: valid bit readable and writable through the data array window.
// R17: bits 31..24 equal F2 select the address array window.
// R18: other address bits of an array access are ignored in decode.
package tlbm_pkg;
    localparam int IDX_W = 5;
    localparam int WAY_W = 2;
    localparam int ENTRIES = 128;
    localparam logic [7:0] DATA_SEL = 8'hf3;
    localparam logic [7:0] ADDR_SEL = 8'hf2;
    localparam int SEL_LSB = 24;
    localparam int IDX_LSB = 12;
    localparam int WAY_LSB = 8;
    // page entry low layout
    localparam int VALID_BIT = 8;
    localparam logic [31:0] DATA_MASK = 32'h1ffffdfe;
    // address array layout: page number 31..17 and 11..10, valid, id 7..0
    localparam logic [31:0] ADDRARR_MASK = 32'hfffe0dff;
    localparam int VPN_HI_LSB = 17;
    localparam int ADDRESS_SPACE_ID_W = 8;
    localparam logic [31:0] VPN_RESET_MARK = 32'h00000000;
    // control register window at 0xf4000000
    localparam logic [7:0] CTRL_SEL = 8'hf4;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ADDRESS_SPACE_ID_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam int CTRL_TE = 0;
    localparam int CTRL_IX = 1;
    localparam int CTRL_RC_LSB = 2;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [1:0] HSIZE_WORD = 2'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : tlbm_pkg

// ==== design/tlbm_arr_if.sv ====
/*
 * Carrier between the bus front end and the entry storage.
 * Assumes both ends on the single block clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface tlbm_arr_if;
    logic req;
    logic wr;
    logic dataWin;
    logic [6:0] slot;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport front (output req, output wr, output dataWin, output slot, output wdata,
                   input rdata);
    modport store (input req, input wr, input dataWin, input slot, input wdata,
                   output rdata);
endinterface : tlbm_arr_if
`default_nettype wire

// ==== design/tlbm_index.sv ====
/*
 * Entry index and way decode for one array access address.
 * Assumes the address space id comes from the control window id register at offset 04.
 */
`timescale 1ns/1ps
`default_nettype none
module tlbm_index (
    input wire logic [31:0] addr, // access address
    input wire logic hashSel, // index_hash_select
    input wire logic [7:0] addressSpaceId, // address_space_id
    output logic [6:0] slot // {index, way}
);
    logic [4:0] idx;
    always_comb begin
        idx = addr[tlbm_pkg::IDX_LSB +: tlbm_pkg::IDX_W]; // R3 R18
        if (hashSel) begin
            idx = idx ^ addressSpaceId[4:0]; // R4
        end
        slot = {idx, addr[tlbm_pkg::WAY_LSB +: tlbm_pkg::WAY_W]}; // R3 R6
    end
endmodule : tlbm_index
`default_nettype wire

// ==== design/tlbm_top.sv ====
/*
 * Memory-mapped translation buffer window: AHB-Lite slave giving privileged
 * software word access to the address array (f2) and data array (f3), plus
 * a small control window (f4) holding control, address space id and status.
 * Assumes hprot[1] marks privileged accesses and a single 40 MHz clock.
 */
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tlbm_top (
    input wire logic clk, // 40 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [3:0] hprot, // protection, bit 1 privileged
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic translationEnable, // translation_enable
    output logic [1:0] replaceWay // replace_way_field
);
    tlbm_arr_if arr ();

    logic [31:0] ctrl_r;
    logic [7:0] address_space_id_r;
    logic [31:0] aphAddr_r;
    logic aphWr_r;
    logic aphOk_r;
    logic aphValid_r;
    logic [31:0] rdMux;
    logic [6:0] slot;
    logic [7:0] lastSel_r;
    logic [15:0] badCnt_r;

    logic phaseOk;
    logic phaseTake;
    assign phaseTake = hsel && hready && htrans[1];
    // privileged, word-sized, aligned only; others complete with no effect but the status last select and refused count
    assign phaseOk = hprot[1] && (hsize[1:0] == tlbm_pkg::HSIZE_WORD) && (hsize[2] == 1'b0)
                     && (haddr[1:0] == 2'b00); // R14 R15

    always_ff @(posedge clk) begin
        if (rst) begin
            aphValid_r <= 1'b0;
            aphWr_r <= 1'b0;
            aphOk_r <= 1'b0;
            aphAddr_r <= 32'h00000000;
        end else if (hready) begin
            aphValid_r <= phaseTake;
            aphWr_r <= hwrite;
            aphOk_r <= phaseOk;
            aphAddr_r <= haddr; // R7
        end
    end

    tlbm_index u_index (
        .addr(aphAddr_r),
        .hashSel(ctrl_r[tlbm_pkg::CTRL_IX]),
        .addressSpaceId(address_space_id_r),
        .slot(slot)
    );

    logic isData;
    logic isAddr;
    logic isCtrl;
    assign isData = aphAddr_r[31:tlbm_pkg::SEL_LSB] == tlbm_pkg::DATA_SEL; // R1 R2
    assign isAddr = aphAddr_r[31:tlbm_pkg::SEL_LSB] == tlbm_pkg::ADDR_SEL; // R17
    assign isCtrl = aphAddr_r[31:tlbm_pkg::SEL_LSB] == tlbm_pkg::CTRL_SEL;

    logic doWr;
    assign doWr = aphValid_r && aphOk_r && aphWr_r;

    assign arr.req = aphValid_r && aphOk_r && (isData || isAddr);
    assign arr.wr = doWr;
    assign arr.dataWin = isData;
    assign arr.slot = slot;
    assign arr.wdata = hwdata;

    tlbm_store u_store (
        .clk(clk),
        .rst(rst),
        .port(arr)
    );

    // control and id registers; the replace way is a plain field of ctrl_r loaded
    // only by software control writes, so its duplicate-page hazard is left to software measures
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= tlbm_pkg::CTRL_RESET;
            address_space_id_r <= 8'h00;
        end else if (doWr && isCtrl) begin
            if (aphAddr_r[7:0] == tlbm_pkg::CTRL_OFS) begin
                ctrl_r <= {28'h0000000, hwdata[3:0]}; // R9
            end
            if (aphAddr_r[7:0] == tlbm_pkg::ADDRESS_SPACE_ID_OFS) begin
                address_space_id_r <= hwdata[7:0];
            end
        end
    end

    // status: last window select seen, count of refused accesses
    always_ff @(posedge clk) begin
        if (rst) begin
            lastSel_r <= 8'h00;
            badCnt_r <= 16'h0000;
        end else if (aphValid_r) begin
            lastSel_r <= aphAddr_r[31:24];
            if (!aphOk_r) begin
                badCnt_r <= badCnt_r + 16'h0001;
            end
        end
    end

    always_comb begin
        rdMux = 32'h00000000;
        if (aphValid_r && aphOk_r && !aphWr_r) begin
            if (isData || isAddr) begin
                rdMux = arr.rdata;
            end else if (isCtrl) begin
                case (aphAddr_r[7:0])
                    tlbm_pkg::CTRL_OFS: rdMux = ctrl_r;
                    tlbm_pkg::ADDRESS_SPACE_ID_OFS: rdMux = {24'h000000, address_space_id_r};
                    tlbm_pkg::STAT_OFS: rdMux = {8'h00, lastSel_r, badCnt_r};
                    default: rdMux = 32'h00000000;
                endcase
            end
        end
    end

    assign hrdata = rdMux;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign translationEnable = ctrl_r[tlbm_pkg::CTRL_TE];
    assign replaceWay = ctrl_r[tlbm_pkg::CTRL_RC_LSB +: 2];
endmodule : tlbm_top
`default_nettype wire

// ==== design/tlbm_store.sv ====
/*
 * Entry storage: data longwords, valid bits and address array words.
 * Assumes requests come from the front end one per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tlbm_store (
    input wire logic clk, // block clock
    input wire logic rst, // synchronous reset
    tlbm_arr_if.store port // array access
);
    logic [31:0] dataMem [tlbm_pkg::ENTRIES];
    logic [31:0] addrMem [tlbm_pkg::ENTRIES];
    logic [tlbm_pkg::ENTRIES-1:0] valid_r;

    // page numbers deliberately have no reset; only valid clears
    always_ff @(posedge clk) begin
        if (port.req && port.wr) begin
            if (port.dataWin) begin
                dataMem[port.slot] <= port.wdata & tlbm_pkg::DATA_MASK; // R5 R6 R7
            end else begin
                addrMem[port.slot] <= port.wdata & tlbm_pkg::ADDRARR_MASK; // R10
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            valid_r <= '0;
        end else if (port.req && port.wr) begin
            valid_r[port.slot] <= port.wdata[tlbm_pkg::VALID_BIT]; // R8 R16
        end
    end

    // masking on read as well keeps never-written slots from showing unknown
    // bits in the fixed-zero fields
    always_comb begin
        if (port.dataWin) begin
            port.rdata = dataMem[port.slot] & tlbm_pkg::DATA_MASK; // R5 R6
        end else begin
            port.rdata = addrMem[port.slot] & tlbm_pkg::ADDRARR_MASK; // R17
        end
        port.rdata[tlbm_pkg::VALID_BIT] = valid_r[port.slot]; // R16
    end
endmodule : tlbm_store
`default_nettype wire

// ==== verification/tlbm_top_chk.sv ====
/* assertions on the tlbm_top ports: bus answer, refusals, layouts, control
   assumes it is bound onto tlbm_top by the bind after the module */
`timescale 1ns/1ps
`default_nettype none
module tlbm_chk (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [3:0] hprot, // protection
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // ready in
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // ready out
    input wire logic hresp, // response
    input wire logic translationEnable, // translation on
    input wire logic [1:0] replaceWay // replace way
);
    logic req;
    logic tk;
    logic ctrlWr;
    logic [31:0] wdPrev_r;
    assign req = hsel && hready && htrans[1];
    assign tk = req && hprot[1] && hsize == 3'h2 && haddr[1:0] == 2'h0;
    assign ctrlWr = tk && hwrite && haddr == 32'hf4000000;
    // write data of the data phase, compared one edge after it lands
    always_ff @(posedge clk) begin
        wdPrev_r <= hwdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_READY: assert property (hreadyout) else $error("wait state");
    AST_OKAY: assert property (!hresp) else $error("error response");
    AST_PRIV: assert property (req && !hwrite && !hprot[1] |=> hrdata == 32'h0)
        else $error("user read gave data");
    AST_SIZE: assert property (req && !hwrite && hsize != 3'h2 |=> hrdata == 32'h0)
        else $error("narrow read gave data");
    AST_REGION: assert property (tk && !hwrite && !(haddr[31:24] inside {8'hf2, 8'hf3, 8'hf4})
        |=> hrdata == 32'h0) else $error("unmapped read gave data");
    AST_IDLE: assert property (!req |=> hrdata == 32'h0) else $error("idle data");
    AST_LAYOUT: assert property (tk && !hwrite && haddr[31:24] == tlbm_pkg::DATA_SEL
        |=> (hrdata & ~tlbm_pkg::DATA_MASK) == 32'h0) else $error("data layout");
    AST_ADDRARR: assert property (tk && !hwrite && haddr[31:24] == tlbm_pkg::ADDR_SEL
        |=> hrdata[16:12] == 5'h0) else $error("address array index bits");
    AST_CTRL: assert property (ctrlWr |-> ##2 (translationEnable == wdPrev_r[0]
        && replaceWay == wdPrev_r[3:2])) else $error("control bits");
    AST_HOLD: assert property ($changed(translationEnable) |-> $past(ctrlWr, 2))
        else $error("enable moved");
endmodule : tlbm_chk
bind tlbm_top tlbm_chk chk_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .translationEnable(translationEnable), .replaceWay(replaceWay));
`default_nettype wire

// ==== verification/tlbm_top_tb.sv ====
/* self-checking bench for tlbm_top, AHB-Lite master in the bench
   assumes the checker file binds its assertions onto the design */
`timescale 1ns/1ps
`default_nettype none
module tlbm_top_tb;
    localparam logic [31:0] DM = tlbm_pkg::DATA_MASK;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] hprot = 4'h3;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout;
    logic hresp;
    logic translationEnable;
    logic [1:0] replaceWay;
    int n_errors = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    tlbm_top dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .translationEnable(translationEnable), .replaceWay(replaceWay));
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // requests change just after a rising edge; ready and read data are taken
    // at the rising edge that closes each phase, before that edge's updates land
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
        input logic [2:0] sz, input logic [3:0] pr);
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        hprot <= pr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 3'h2, 4'h3);
    endtask : wr
    task automatic rdw(input logic [31:0] a);
        xfer(a, 1'b0, 32'h0, 3'h2, 4'h3);
    endtask : rdw
    // page numbers come up undefined, so every entry is parked before translation
    task automatic t_init;
        for (int i = 0; i < 128; i++) begin
            wr(32'hf2000000 | 32'((i / 4) << 12) | 32'((i % 4) << 8), 32'hf0000000);
        end
        rdw(32'hf201f300);
        check(rd, 32'hf0000000);
    endtask : t_init
    task automatic t_data;
        for (int k = 0; k < 16; k++) begin
            if (k < 8) begin
                wr(32'hf3000000 + 32'((k % 4) * 256 + (k / 4) * 'h1f000), 32'h9e3779b9 * (k + 1));
            end else begin
                rdw(32'hf3000000 + 32'((k % 4) * 256 + (k / 4 - 2) * 'h1f000));
                check(rd, (32'h9e3779b9 * (k - 7)) & DM);
            end
        end
        wr(32'hf3fe5efc, 32'hffffffff);
        rdw(32'hf3005200);
        check(rd, DM);
    endtask : t_data
    task automatic t_valid;
        wr(32'hf3007100, 32'h00000100);
        rdw(32'hf2007100);
        check(rd & 32'h100, 32'h100);
        wr(32'hf2007100, 32'hf0000000);
        rdw(32'hf3007100);
        check(rd, 32'h0);
        rdw(32'hf2007100);
        check(rd, 32'hf0000000);
    endtask : t_valid
    task automatic t_hash;
        wr(32'hf4000004, 32'h15);
        wr(32'hf4000000, 32'h2);
        wr(32'hf3003300, 32'h12345000);
        wr(32'hf4000000, 32'h0);
        rdw(32'hf3016300);
        check(rd, 32'h12345000 & DM);
    endtask : t_hash
    task automatic t_refuse;
        xfer(32'hf3005200, 1'b1, 32'h0, 3'h2, 4'h1);
        xfer(32'hf3005200, 1'b1, 32'h0, 3'h0, 4'h3);
        xfer(32'hf3005200, 1'b0, 32'h0, 3'h2, 4'h1);
        check(rd, 32'h0);
        xfer(32'hf3005200, 1'b0, 32'h0, 3'h0, 4'h3);
        check(rd, 32'h0);
        rdw(32'hf3005200);
        check(rd, DM);
        rdw(32'hf1005200);
        check(rd, 32'h0);
        // status: last window byte f1, four refused accesses
        rdw(32'hf4000008);
        check(rd, 32'h00f10004);
    endtask : t_refuse
    task automatic t_ctrl;
        rdw(32'hf4000000);
        check(rd, 32'h0);
        wr(32'hf4000000, 32'hd);
        @(posedge clk);
        check({29'h0, replaceWay, translationEnable}, 32'h7);
        wr(32'hf4000000, 32'h0);
    endtask : t_ctrl
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        $display("ERROR %0t watchdog expired", $time);
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_init();
        t_ctrl();
        t_data();
        t_valid();
        t_hash();
        t_refuse();
        close_out();
    end
endmodule : tlbm_top_tb
`default_nettype wire
